// ### logic/hlt_pkg.sv
// Purpose: shared constants and types of the serial link transmitter
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   offsets are byte addresses
package hlt_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          BYTE_W        = 8;
  localparam int          FIFO_W        = 9;
  localparam int          FIFO_DEPTH    = 8;
  localparam logic [7:0]  OFF_CFG       = 8'h00;
  localparam logic [7:0]  OFF_TXD       = 8'h04;
  localparam logic [7:0]  OFF_STAT      = 8'h08;
  localparam logic [7:0]  CFG_RST       = 8'h00;
  localparam int          CFG_EN_B      = 0;
  localparam int          CFG_CRC_B     = 1;
  localparam int          CFG_ABORT_B   = 2;
  localparam int          CFG_TS0_B     = 3;
  localparam int          CFG_REQ_IE_B  = 4;
  localparam int          CFG_UDR_IE_B  = 5;
  localparam int          TXD_EOF_B     = 8;
  localparam int          ST_REQ_B      = 0;
  localparam int          ST_UDR_B      = 1;
  localparam int          ST_FULL_B     = 2;
  localparam int          ST_EMPTY_B    = 3;
  localparam int          ST_FRAME_B    = 4;
  localparam int          ST_ABORT_B    = 5;
  localparam logic [7:0]  FLAG_OCTET    = 8'h7E;
  localparam logic [7:0]  ABORT_OCTET   = 8'h7F;
  localparam logic [2:0]  ONES_LIMIT    = 3'h5;
  localparam logic [15:0] FCS_POLY      = 16'h8408;
  localparam logic [15:0] FCS_INIT      = 16'hFFFF;
  localparam logic [3:0]  FCS_LAST      = 4'hF;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {ST_FLAG, ST_DATA, ST_FCS, ST_ABORT} hlt_state_e;
endpackage

// ### logic/hlt_fifo.sv
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   first word falls through; full and empty are exact
`timescale 1ns/100ps
module hlt_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wptr_q;
  logic [AW:0]  rptr_q;
  wire          push = in_valid & in_ready;
  wire          pop  = out_valid & out_ready;

  assign in_ready  = (wptr_q[AW] == rptr_q[AW]) || (wptr_q[AW-1:0] != rptr_q[AW-1:0]);
  assign out_valid = (wptr_q != rptr_q);
  assign out_data  = mem_q[rptr_q[AW-1:0]];

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wptr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (push) wptr_q <= wptr_q + 1'b1;
      if (pop) rptr_q <= rptr_q + 1'b1;
    end
  end
endmodule

// ### logic/hlt_fcs16.sv
// Purpose: bit-serial 16-bit frame check sequence, reflected form
// Assumes: data bits arrive least significant first
// Notes:   clear wins over update
`timescale 1ns/100ps
module hlt_fcs16 (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic        din,
  output logic [15:0]      crc
);
  import hlt_pkg::*;
  logic [15:0] crc_q;
  wire  [15:0] shifted = {1'b0, crc_q[15:1]};
  wire  [15:0] crc_d   = (crc_q[0] ^ din) ? (shifted ^ FCS_POLY) : shifted;

  assign crc = crc_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || clr) crc_q <= FCS_INIT;
    else if (en) crc_q <= crc_d;
  end
endmodule

// ### logic/hlt_link_tx_unit.sv
// Purpose: serial data link transmitter for one E1 channel, AXI4-Lite registers
// Assumes: framer supplies a strobe per E1 bit and timeslot position levels
// Notes:
// What this block does
// - While enabled and idle, send flag octet 01111110 repeatedly.
// - Frame bytes enter a buffered data register so the next loads early.
// - Each byte moved into the shifter raises a byte request flag.
// - After last byte send FCS if enabled, else closing flag; then flags.
// - Insert a zero after five ones inside data and FCS bits.
// - While the abort bit is set, send abort octets continuously.
// - Buffer empty mid-frame sends abort and sets the underrun flag.
// - Request and underrun flags each have an enable driving irq_out_n low.
// - Flags and frames start only when the enable bit is set.
// - Link bits go into timeslot 16 or timeslot 0 national bits.
// - When disabled, output link clock and pass external link data.
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module hlt_link_tx_unit #(
  parameter int FIFO_DEPTH = hlt_pkg::FIFO_DEPTH
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [hlt_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [hlt_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [hlt_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [hlt_pkg::DATA_W-1:0]      rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  input  wire logic                       e1_bit_stb,
  input  wire logic                       e1_in_ts16,
  input  wire logic                       e1_in_ts0_nat,
  output logic                            link_bit_out,
  output logic                            link_bit_valid,
  input  wire logic                       ext_link_data_in,
  output logic                            ext_link_clock_out,
  output logic                            irq_out_n
);
  import hlt_pkg::*;

  // Write and read channel holding registers, config and sticky flags
  logic                aw_hold_q;
  logic [ADDR_W-1:0]   aw_addr_q;
  logic                w_hold_q;
  logic [DATA_W-1:0]   w_data_q;
  logic [3:0]          w_strb_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [DATA_W-1:0]   rdata_q;
  logic [1:0]          rresp_q;
  logic [7:0]          cfg_q;
  logic                req_q;
  logic                udr_q;

  // Serializer state
  hlt_state_e          st_q;
  hlt_state_e          st_d;
  logic [2:0]          idx_q;
  logic [2:0]          idx_d;
  logic [2:0]          ones_q;
  logic [2:0]          ones_d;
  logic [7:0]          sh_q;
  logic [7:0]          sh_d;
  logic                eof_q;
  logic                eof_d;
  logic [3:0]          fcs_idx_q;
  logic [3:0]          fcs_idx_d;
  logic                bit_q;
  logic                bit_vld_q;
  logic                lclk_q;
  logic                pop;
  logic                req_set;
  logic                udr_set;
  logic                crc_clr;
  logic                crc_en;
  logic                tx_bit;

  // FIFO and FCS wires
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic [FIFO_W-1:0]   fifo_out_data;
  logic [15:0]         crc;

  wire cfg_en     = cfg_q[CFG_EN_B];
  wire cfg_crc    = cfg_q[CFG_CRC_B];
  wire cfg_abort  = cfg_q[CFG_ABORT_B];
  wire cfg_ts0    = cfg_q[CFG_TS0_B];
  wire cfg_req_ie = cfg_q[CFG_REQ_IE_B];
  wire cfg_udr_ie = cfg_q[CFG_UDR_IE_B];

  // Register bus decode
  wire wr_is_cfg  = (aw_addr_q == OFF_CFG);
  wire wr_is_txd  = (aw_addr_q == OFF_TXD);
  wire wr_is_stat = (aw_addr_q == OFF_STAT);
  wire wr_mapped  = wr_is_cfg | wr_is_txd | wr_is_stat;
  // A data write waits for FIFO room, which holds off bvalid and the bus
  wire wr_go      = aw_hold_q & w_hold_q & ~bvalid_q & (~wr_is_txd | fifo_in_ready);
  wire wr_lane0   = wr_go & w_strb_q[0];
  wire cfg_wr     = wr_lane0 & wr_is_cfg;
  wire txd_push   = wr_lane0 & wr_is_txd;
  wire stat_wr    = wr_lane0 & wr_is_stat;
  wire req_clr    = stat_wr & w_data_q[ST_REQ_B];
  wire udr_clr    = stat_wr & w_data_q[ST_UDR_B];
  wire ar_go      = arvalid & ~rvalid_q;
  wire rd_is_cfg  = (araddr == OFF_CFG);
  wire rd_is_txd  = (araddr == OFF_TXD);
  wire rd_is_stat = (araddr == OFF_STAT);
  wire in_frame   = (st_q == ST_DATA) | (st_q == ST_FCS);
  wire [7:0] stat_word = {2'b00, (st_q == ST_ABORT), in_frame, ~fifo_out_valid,
                          ~fifo_in_ready, udr_q, req_q};
  wire [DATA_W-1:0] rd_word = rd_is_cfg  ? {24'h00_0000, cfg_q} :
                              rd_is_stat ? {24'h00_0000, stat_word} :
                              '0;
  wire rd_mapped  = rd_is_cfg | rd_is_txd | rd_is_stat;

  assign awready = ~aw_hold_q;
  assign wready  = ~w_hold_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = ~rvalid_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && !aw_hold_q) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_go) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && !w_hold_q) begin
      w_hold_q <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_go) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (ar_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) cfg_q <= CFG_RST;
    else if (cfg_wr) cfg_q <= w_data_q[7:0];
  end

  // Sticky flags: a new event in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q <= 1'b0;
      udr_q <= 1'b0;
    end else begin
      req_q <= req_set | (req_q & ~req_clr);
      udr_q <= udr_set | (udr_q & ~udr_clr);
    end
  end

  assign irq_out_n = ~((req_q & cfg_req_ie) | (udr_q & cfg_udr_ie));

  // Double buffering: shifter plus FIFO, so writes run ahead of the line
  hlt_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (txd_push),
    .in_ready  (fifo_in_ready),
    .in_data   (w_data_q[FIFO_W-1:0]),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  hlt_fcs16 u_fcs (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (crc_clr),
    .en      (crc_en),
    .din     (tx_bit),
    .crc     (crc)
  );

  // Link bit slot picked from the configured timeslot
  wire bit_en  = e1_bit_stb & (cfg_ts0 ? e1_in_ts0_nat : e1_in_ts16);
  // Not gated by state, so a zero owed by the last frame bit still goes out
  wire stuffed = (ones_q == ONES_LIMIT);
  wire octet_end = ~stuffed & ((st_q == ST_FCS) ? (fcs_idx_q == FCS_LAST) : (idx_q == 3'h7));

  always_comb begin
    case (st_q)
      ST_DATA:  tx_bit = sh_q[idx_q];
      ST_FCS:   tx_bit = ~crc[fcs_idx_q];
      ST_ABORT: tx_bit = ABORT_OCTET[idx_q];
      default:  tx_bit = FLAG_OCTET[idx_q];
    endcase
    if (stuffed) tx_bit = 1'b0;
  end

  always_comb begin
    st_d      = st_q;
    idx_d     = idx_q;
    ones_d    = ones_q;
    sh_d      = sh_q;
    eof_d     = eof_q;
    fcs_idx_d = fcs_idx_q;
    pop       = 1'b0;
    req_set   = 1'b0;
    udr_set   = 1'b0;
    crc_clr   = 1'b0;
    crc_en    = 1'b0;
    if (!cfg_en) begin
      st_d      = ST_FLAG;
      idx_d     = 3'h0;
      ones_d    = 3'h0;
      fcs_idx_d = 4'h0;
    end else if (bit_en) begin
      if (cfg_abort && st_q != ST_ABORT) begin
        st_d      = ST_ABORT;
        idx_d     = 3'h0;
        ones_d    = 3'h0;
        fcs_idx_d = 4'h0;
      end else if (stuffed) begin
        ones_d = 3'h0;
      end else begin
        ones_d = (in_frame && tx_bit) ? ones_q + 3'h1 : 3'h0;
        crc_en = (st_q == ST_DATA);
        idx_d  = idx_q + 3'h1;
        if (st_q == ST_FCS) fcs_idx_d = fcs_idx_q + 4'h1;
        if (octet_end) begin
          case (st_q)
            ST_FLAG: begin
              if (cfg_abort) begin
                st_d = ST_ABORT;
              end else if (fifo_out_valid) begin
                st_d    = ST_DATA;
                sh_d    = fifo_out_data[BYTE_W-1:0];
                eof_d   = fifo_out_data[TXD_EOF_B];
                pop     = 1'b1;
                req_set = 1'b1;
                crc_clr = 1'b1;
              end
            end
            ST_DATA: begin
              if (eof_q) begin
                st_d = cfg_crc ? ST_FCS : ST_FLAG;
              end else if (fifo_out_valid) begin
                sh_d    = fifo_out_data[BYTE_W-1:0];
                eof_d   = fifo_out_data[TXD_EOF_B];
                pop     = 1'b1;
                req_set = 1'b1;
              end else begin
                st_d    = ST_ABORT;
                udr_set = 1'b1;
              end
            end
            ST_FCS:   st_d = ST_FLAG;
            ST_ABORT: st_d = cfg_abort ? ST_ABORT : ST_FLAG;
            default:  st_d = ST_FLAG;
          endcase
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q      <= ST_FLAG;
      idx_q     <= 3'h0;
      ones_q    <= 3'h0;
      sh_q      <= 8'h00;
      eof_q     <= 1'b0;
      fcs_idx_q <= 4'h0;
    end else begin
      st_q      <= st_d;
      idx_q     <= idx_d;
      ones_q    <= ones_d;
      sh_q      <= sh_d;
      eof_q     <= eof_d;
      fcs_idx_q <= fcs_idx_d;
    end
  end

  // Disabled: external source drives the slot, sampled at our clock fall
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_q     <= 1'b1;
      bit_vld_q <= 1'b0;
      lclk_q    <= 1'b1;
    end else begin
      bit_vld_q <= bit_en;
      lclk_q    <= cfg_en | ~bit_en;
      if (bit_en) bit_q <= cfg_en ? tx_bit : ext_link_data_in;
    end
  end

  assign link_bit_out       = bit_q;
  assign link_bit_valid     = bit_vld_q;
  assign ext_link_clock_out = lclk_q;
endmodule

// ### sim/hlt_checker.sv
// Purpose: bus and link timing checks on the transmitter ports
// Assumes: one clock, synchronous active-low reset
// Notes: config is not visible here, so slot checks are loose
`timescale 1ns/100ps
module hlt_checker
  import hlt_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic              e1_bit_stb,
  input wire logic              e1_in_ts16,
  input wire logic              e1_in_ts0_nat,
  input wire logic              link_bit_valid,
  input wire logic              ext_link_clock_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire aw_go = awvalid && awready && wvalid && wready;
  wire bad_w = awaddr != OFF_CFG && awaddr != OFF_TXD && awaddr != OFF_STAT;
  wire bad_r = araddr != OFF_CFG && araddr != OFF_TXD && araddr != OFF_STAT;
  property p_wr_lat; aw_go && !bvalid && awaddr != OFF_TXD |-> ##2 bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_wr_err;
    aw_go && !bvalid && bad_w |-> ##2 bvalid && bresp == RESP_SLVERR;
  endproperty
  a_wr_err: assert property (p_wr_err) else $error("unmapped write not refused");
  property p_b_done; bvalid && bready && awready && !awvalid |=> !bvalid && awready; endproperty
  a_b_done: assert property (p_b_done) else $error("write answer not retired");
  property p_b_busy; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_busy: assert property (p_b_busy) else $error("write answer dropped early");
  property p_rd_lat; arvalid && arready |=> rvalid && !arready; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_err; arvalid && arready && bad_r |=> rresp == RESP_SLVERR; endproperty
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
  property p_r_done; rvalid && rready |=> !rvalid; endproperty
  a_r_done: assert property (p_r_done) else $error("read answer not retired");
  property p_slot;
    link_bit_valid |-> $past(e1_bit_stb) && ($past(e1_in_ts16) || $past(e1_in_ts0_nat));
  endproperty
  a_slot: assert property (p_slot) else $error("link bit outside a slot");
  property p_lclk; !ext_link_clock_out |-> $past(e1_bit_stb) ##1 ext_link_clock_out; endproperty
  a_lclk: assert property (p_lclk) else $error("link clock low phase wrong");
  c_err: cover property (bvalid && bresp == RESP_SLVERR);
  c_bit: cover property (link_bit_valid);
  c_clk: cover property (!ext_link_clock_out);
endmodule
bind hlt_link_tx_unit hlt_checker u_hlt_checker (.aclk, .aresetn, .awaddr, .awvalid,
  .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
  .rresp, .rvalid, .rready, .e1_bit_stb, .e1_in_ts16, .e1_in_ts0_nat, .link_bit_valid,
  .ext_link_clock_out);

// ### sim/hlt_framer_model.sv
// Purpose: framer side: slot strobes, slot levels, external link data
// Assumes: a strobe every fourth cycle while run is high
// Notes: run low stalls the link so the buffer can fill
`timescale 1ns/100ps
module hlt_framer_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic ext_link_clock_out,
  output logic     e1_bit_stb,
  output logic     e1_in_ts16,
  output logic     e1_in_ts0_nat,
  output logic     ext_link_data_in
);
  int          seed = 78977;
  logic [1:0]  div = 2'h0;
  logic [31:0] r;
  initial begin
    e1_bit_stb = 0;
    e1_in_ts16 = 0;
    e1_in_ts0_nat = 0;
    ext_link_data_in = 0;
  end
  always @(posedge aclk) begin
    r = $random(seed);
    div <= aresetn ? div + 2'h1 : 2'h0;
    e1_bit_stb <= aresetn && run && div == 2'h3;
    if (div == 2'h3) begin
      e1_in_ts16 <= r[0];
      e1_in_ts0_nat <= r[1];
    end
    // New data only after the low phase, so it is settled by the next strobe
    if (!ext_link_clock_out) ext_link_data_in <= r[2];
  end
endmodule

// ### sim/tb_hlt_link_tx_unit.sv
// Purpose: self-checking bench for the link transmitter
// Assumes: bits of interest follow idle flags
// Notes: expected streams come from a local bit model
`timescale 1ns/100ps
module tb_hlt_link_tx_unit;
  import hlt_pkg::*;
  localparam logic [7:0] EN = 8'h01 << CFG_EN_B, CRC = 8'h01 << CFG_CRC_B;
  localparam logic [7:0] ABT = 8'h01 << CFG_ABORT_B, TS0 = 8'h01 << CFG_TS0_B;
  localparam logic [7:0] RIE = 8'h01 << CFG_REQ_IE_B, UIE = 8'h01 << CFG_UDR_IE_B;
  logic              aclk = 0, aresetn = 0, run = 1, mon = 1, ext_q = 0, sel_q = 0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [3:0]        wstrb = 4'h0;
  logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic              awready, wready, bvalid, arready, rvalid, irq_out_n;
  logic [1:0]        bresp, rresp;
  logic              e1_bit_stb, e1_in_ts16, e1_in_ts0_nat, ext_link_data_in;
  logic              link_bit_out, link_bit_valid, ext_link_clock_out;
  logic [7:0]        cfg = 8'h00;
  logic [15:0]       crc;
  int                failures = 0, n_compared = 0, seed = 78977, ones;
  bit                rx[$], ex[$];
  always #2.5 aclk = ~aclk;
  hlt_link_tx_unit u_hlt_link_tx_unit (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .e1_bit_stb, .e1_in_ts16, .e1_in_ts0_nat, .link_bit_out,
    .link_bit_valid, .ext_link_data_in, .ext_link_clock_out, .irq_out_n);
  hlt_framer_model u_hlt_framer_model (.aclk, .aresetn, .run, .ext_link_clock_out,
    .e1_bit_stb, .e1_in_ts16, .e1_in_ts0_nat, .ext_link_data_in);
  task automatic print_verdict();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, w, input string s);
    n_compared++;
    if (g !== w) begin
      failures++;
      $display("unexpected at %0t: %s %h/%h", $time, s, g, w);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit ad = 0, dd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) ad = 1;
      if (wready) dd = 1;
      if (ad) awvalid <= 0;
      if (dd) wvalid <= 0;
    end while (!(ad && dd));
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 0;
    chk(bresp, r, "bresp");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, m, input logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 0;
    chk(rdata & m, d, "rdata");
    chk(rresp, r, "rresp");
  endtask
  task automatic put(input logic [7:0] v, input bit stf);
    for (int i = 0; i < 8; i++) begin
      ex.push_back(v[i]);
      ones = (stf && v[i]) ? ones + 1 : 0;
      if (ones == 5) ex.push_back(1'b0);
      if (ones == 5) ones = 0;
    end
  endtask
  function automatic bit found();
    for (int s = 0; s + ex.size() <= rx.size(); s++) begin
      int k;
      for (k = 0; k < ex.size() && rx[s+k] == ex[k]; k++);
      if (k == ex.size()) return 1;
    end
    return 0;
  endfunction
  task automatic look(input int n);
    while (rx.size() < n) @(posedge aclk);
    chk(found(), 1, "bits");
  endtask
  task automatic setcfg(input logic [7:0] v);
    mon <= 0;
    cfg <= v;
    wr(OFF_CFG, v, RESP_OKAY);
    repeat (20) @(posedge aclk);
    rx.delete();
    ex.delete();
    mon <= 1;
  endtask
  task automatic frame(input int n, input bit last, udr, stall);
    logic [7:0] b;
    rx.delete();
    ex.delete();
    // A whole flag must be seen ahead of the first data bit
    while (rx.size() < 8) @(posedge aclk);
    crc = FCS_INIT;
    run <= !stall;
    put(FLAG_OCTET, 0);
    for (int i = 0; i < n; i++) begin
      b = (i == 1) ? 8'hFF : 8'($random(seed));
      for (int k = 0; k < 8; k++) crc = (crc >> 1) ^ ((crc[0] ^ b[k]) ? FCS_POLY : 16'h0000);
      put(b, 1);
      if (stall && i == n - 1) fork
        wr(OFF_TXD, {last, b}, RESP_OKAY);
        begin
          repeat (40) @(posedge aclk);
          rd(OFF_STAT, 32'h1 << ST_FULL_B, 32'h1 << ST_FULL_B, RESP_OKAY);
          run <= 1;
        end
      join
      else wr(OFF_TXD, {last && i == n - 1, b}, RESP_OKAY);
    end
    if (udr) put(ABORT_OCTET, 0);
    else if (cfg[CFG_CRC_B]) put(~crc[7:0], 1);
    if (!udr && cfg[CFG_CRC_B]) put(~crc[15:8], 1);
    if (!udr) put(FLAG_OCTET, 0);
    look(ex.size() + 24);
  endtask
  always @(posedge aclk) begin
    if (mon && link_bit_valid === 1'b1) begin
      rx.push_back(link_bit_out);
      chk(sel_q, 1, "slot");
      if (!cfg[CFG_EN_B]) chk(link_bit_out, ext_q, "ext");
    end
    ext_q <= ext_link_data_in;
    sel_q <= e1_bit_stb && (cfg[CFG_TS0_B] ? e1_in_ts0_nat : e1_in_ts16);
  end
  initial begin
    repeat (40000) @(posedge aclk);
    failures++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rd(OFF_CFG, 0, '1, RESP_OKAY);
    rd(OFF_STAT, 32'h1 << ST_EMPTY_B, 32'h3F, RESP_OKAY);
    rd(8'h0C, 0, '1, RESP_SLVERR);
    wr(8'h0C, 0, RESP_SLVERR);
    while (rx.size() < 24) @(posedge aclk);
    setcfg(EN | RIE);
    put(FLAG_OCTET, 0);
    put(FLAG_OCTET, 0);
    look(40);
    frame(5, 1, 0, 0);
    chk(irq_out_n, 0, "irq");
    wr(OFF_STAT, 32'h1 << ST_REQ_B, RESP_OKAY);
    @(posedge aclk);
    chk(irq_out_n, 1, "irq");
    setcfg(EN | CRC | TS0);
    frame(6, 1, 0, 0);
    setcfg(EN | CRC | UIE);
    frame(2, 0, 1, 0);
    rd(OFF_STAT, 32'h1 << ST_UDR_B, 32'h1 << ST_UDR_B, RESP_OKAY);
    chk(irq_out_n, 0, "irq");
    wr(OFF_STAT, 32'h3, RESP_OKAY);
    @(posedge aclk);
    chk(irq_out_n, 1, "irq");
    setcfg(EN | CRC);
    frame(9, 1, 0, 1);
    rd(OFF_STAT, 32'h1 << ST_EMPTY_B, 32'h1 << ST_EMPTY_B, RESP_OKAY);
    setcfg(EN | ABT);
    put(ABORT_OCTET, 0);
    put(ABORT_OCTET, 0);
    look(40);
    rd(OFF_STAT, 32'h1 << ST_ABORT_B, 32'h1 << ST_ABORT_B, RESP_OKAY);
    print_verdict();
  end
endmodule
